/* File: logic/sss_ctrl.sv */
// Purpose: flow-through synchronous burst sram core with snooze control
// Assumes: address, write and select pins meet setup and hold to the rising edge
// Notes: sleep, burst order and output enable pins are asynchronous and synchronised
`timescale 1ns/1ps
module sss_ctrl #(
  parameter int AW = sss_pkg::ADDR_W,
  parameter int DW = sss_pkg::DATA_W,
  parameter int NL = sss_pkg::LANES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sleep_request,
  input wire logic burst_order_select_n,
  input wire logic output_enable_n,
  input wire logic [AW-1:0] address,
  input wire logic address_load_n,
  input wire logic burst_advance_n,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b,
  input wire logic chip_select_c_n,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [NL-1:0] byte_lane_write_n,
  input wire logic [DW-1:0] data_in,
  output logic [DW-1:0] data_out_q,
  output logic data_oe_n_q,
  output logic snooze_q
);

  localparam int BW = sss_pkg::BURST_W;
  localparam int LW = DW / NL;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic rst_a_q;
  logic rst_n_q;
  logic sleep_a_q;
  logic sleep_s_q;
  logic order_a_q;
  logic order_s_q;
  logic oe_a_q;
  logic oe_s_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  // sleep request active high; second stage alone gates the input sampling
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      sleep_a_q <= sss_pkg::RST_SLEEP;
      sleep_s_q <= sss_pkg::RST_SLEEP;
    end
    else
    begin
      sleep_a_q <= sleep_request; // RULE_08
      sleep_s_q <= sleep_a_q;
    end
  end

  // an open order pin is pulled high outside, so reset favours xor order
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      order_a_q <= sss_pkg::RST_ORDER_N;
      order_s_q <= sss_pkg::RST_ORDER_N;
      oe_a_q <= sss_pkg::RST_OE_N;
      oe_s_q <= sss_pkg::RST_OE_N;
    end
    else
    begin
      order_a_q <= burst_order_select_n;
      order_s_q <= order_a_q;
      oe_a_q <= output_enable_n;
      oe_s_q <= oe_a_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode, taken on the rising edge only

  logic awake;
  logic chip_en;
  logic load;
  logic advance;
  logic any_write;
  logic [NL-1:0] lane_we;
  logic [AW-1:0] base_q;
  logic [BW-1:0] count_q;
  logic [BW-1:0] count_d;
  logic [BW-1:0] beat;
  logic [AW-1:0] op_addr;
  logic active_q;
  logic wr_fire;
  logic rd_fire;
  sss_pkg::sss_state_e state_q;

  // inputs are still taken for two edges after sleep rises, then ignored
  assign awake = !sleep_s_q; // RULE_01 RULE_04
  assign chip_en = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign load = awake && !address_load_n;
  assign advance = awake && address_load_n && !burst_advance_n && active_q;
  assign count_d = load ? sss_pkg::RST_COUNT : (advance ? BW'(count_q + 2'h1) : count_q);

  always_comb
  begin
    if (!global_write_n)
      lane_we = '1;
    else if (!byte_write_enable_n)
      lane_we = ~byte_lane_write_n;
    else
      lane_we = '0;
  end

  assign any_write = |lane_we;

  sss_burst_addr #(
    .BW(BW)
  ) u_burst (
    .base(load ? address[BW-1:0] : base_q[BW-1:0]),
    .count(count_d),
    .order_n(order_s_q),
    .beat(beat)
  );

  assign op_addr = load ? {address[AW-1:BW], beat} : {base_q[AW-1:BW], beat};
  assign wr_fire = awake && (load ? chip_en : active_q) && any_write;
  assign rd_fire = awake && (load ? chip_en : active_q) && !any_write;

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      base_q <= '0;
      count_q <= sss_pkg::RST_COUNT;
      active_q <= 1'b0;
    end
    else
    begin
      if (load)
      begin
        base_q <= address; // RULE_07
        active_q <= chip_en;
      end
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage; no write can reach the array while sleep_s_q is high

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_word;

  assign rd_word = mem[op_addr];

  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < NL; i++)
    begin
      if (wr_fire && lane_we[i])
        mem[op_addr][i*LW +: LW] <= data_in[i*LW +: LW]; // RULE_07 RULE_08
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs and state

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      data_out_q <= '0;
    else if (rd_fire)
      data_out_q <= rd_word; // RULE_07
  end

  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      state_q <= sss_pkg::SSS_IDLE;
    else if (sleep_s_q)
      state_q <= sss_pkg::SSS_SNOOZE; // RULE_03
    else if (wr_fire)
      state_q <= sss_pkg::SSS_WRITE;
    else if (rd_fire)
      state_q <= sss_pkg::SSS_READ;
    else
      state_q <= sss_pkg::SSS_IDLE; // RULE_04
  end

  // output enable reaches the bus three edges late: two through its synchroniser, one in the output register
  always_ff @(posedge sys_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      snooze_q <= 1'b0;
      data_oe_n_q <= 1'b1;
    end
    else
    begin
      snooze_q <= sleep_s_q; // RULE_03 RULE_04
      case (state_q)
        sss_pkg::SSS_READ: data_oe_n_q <= !(rd_fire && !oe_s_q);
        sss_pkg::SSS_IDLE: data_oe_n_q <= !(rd_fire && !oe_s_q);
        sss_pkg::SSS_WRITE: data_oe_n_q <= !(rd_fire && !oe_s_q);
        sss_pkg::SSS_SNOOZE: data_oe_n_q <= 1'b1;
        default: data_oe_n_q <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_sample_after_sleep: assert property ( // RULE_01
    @(posedge sys_clk) disable iff (!rst_n_q)
    $rose(sleep_request) |-> awake ##1 awake)
  else $error("inputs ignored too soon after sleep request");

  chk_snooze_entry: assert property ( // RULE_03
    @(posedge sys_clk) disable iff (!rst_n_q)
    $rose(sleep_request) ##1 sleep_request |-> ##2 snooze_q)
  else $error("snooze not reached in time");

  chk_snooze_exit: assert property ( // RULE_04
    @(posedge sys_clk) disable iff (!rst_n_q)
    $fell(sleep_request) ##1 !sleep_request |-> ##1 awake ##1 !snooze_q)
  else $error("snooze not left promptly");

  chk_burst_linear: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (!rst_n_q)
    (!load && !order_s_q) |-> beat == BW'(base_q[BW-1:0] + count_d))
  else $error("linear burst address wrong");

  chk_burst_xor: assert property ( // RULE_05
    @(posedge sys_clk) disable iff (!rst_n_q)
    (advance && order_s_q) |-> beat == (base_q[BW-1:0] ^ BW'(count_q + 2'h1)))
  else $error("interleaved burst address wrong");

  chk_read_on_edge: assert property ( // RULE_07
    @(posedge sys_clk) disable iff (!rst_n_q)
    rd_fire |=> data_out_q == $past(rd_word))
  else $error("read data not taken at the edge");

  chk_snooze_no_write: assert property ( // RULE_08
    @(posedge sys_clk) disable iff (!rst_n_q)
    (snooze_q && sleep_s_q) |-> !wr_fire && data_oe_n_q)
  else $error("array touched during snooze");

  cov_snooze: cover property (@(posedge sys_clk) disable iff (!rst_n_q) $rose(snooze_q));
  cov_xor_burst: cover property (@(posedge sys_clk) disable iff (!rst_n_q) advance && order_s_q);
  cov_add_burst: cover property (@(posedge sys_clk) disable iff (!rst_n_q) advance && !order_s_q);
  cov_write: cover property (@(posedge sys_clk) disable iff (!rst_n_q) wr_fire ##1 rd_fire);

endmodule : sss_ctrl

/* File: pkg/sss_pkg.sv */
// Purpose: shared constants for the snooze and burst control of a synchronous sram
// Assumes: one rising-edge clock, 125 MHz
// Notes: counts are in clock cycles of sys_clk
// Behaviour
// RULE_01: after sleep request rises, keep taking synchronous inputs for two more cycles.
// RULE_02: controller waits two cycles after sleep request falls before new commands.
// RULE_03: enter snooze no later than two cycles after sleep request goes active.
// RULE_04: leave snooze on sleep request inactive with no minimum delay.
// RULE_05: burst order select high gives xor order, low gives add order.
// RULE_06: controller keeps address valid every edge, controls valid while chip enabled.
// RULE_07: every synchronous input is captured on the rising clock edge only.
// RULE_08: sleep request is active high; memory contents survive snooze untouched.
package sss_pkg;

  localparam int ADDR_W = 19;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int BURST_W = 2;

  // snooze timing, in cycles
  localparam int SLEEP_SAMPLE_MIN_CYC = 2;
  localparam int WAKE_SAMPLE_MIN_CYC = 2;
  localparam int SNOOZE_ENTER_MAX_CYC = 2;
  localparam int SNOOZE_EXIT_MIN_CYC = 0;

  // values after reset
  localparam logic RST_SLEEP = 1'b0;
  localparam logic RST_ORDER_N = 1'b1;
  localparam logic RST_OE_N = 1'b1;
  localparam logic [BURST_W-1:0] RST_COUNT = 2'h0;

  typedef enum logic [1:0] {
    SSS_IDLE = 2'b00,
    SSS_READ = 2'b01,
    SSS_WRITE = 2'b10,
    SSS_SNOOZE = 2'b11
  } sss_state_e;

endpackage : sss_pkg

/* File: logic/sss_burst_addr.sv */
// Purpose: low address bits of a burst beat
// Assumes: count starts at zero on each new address
// Notes: order_n high selects xor order, low selects add order
`timescale 1ns/1ps
module sss_burst_addr #(
  parameter int BW = 2
) (
  input wire logic [BW-1:0] base,
  input wire logic [BW-1:0] count,
  input wire logic order_n,
  output logic [BW-1:0] beat
);

  always_comb
  begin
    if (order_n)
      beat = base ^ count; // RULE_05
    else
      beat = BW'(base + count); // RULE_05
  end

endmodule : sss_burst_addr

/* File: tb/sss_host_model.sv */
// Purpose: memory controller model that drives the sram pins
// Assumes: a command changes just after a rising edge and is taken at the next one
// Notes: chip selects enabled unless a scenario deselects; data_in scrambled when not writing
`timescale 1ns/1ps
module sss_host_model (
  input wire logic sys_clk,
  output logic [sss_pkg::ADDR_W-1:0] address,
  output logic address_load_n,
  output logic burst_advance_n,
  output logic chip_select_a_n,
  output logic chip_select_b,
  output logic chip_select_c_n,
  output logic global_write_n,
  output logic byte_write_enable_n,
  output logic [sss_pkg::LANES-1:0] byte_lane_write_n,
  output logic [sss_pkg::DATA_W-1:0] data_in,
  output logic sleep_request,
  output logic burst_order_select_n,
  output logic output_enable_n
);
  initial
  begin
    {address, data_in} = '0;
    {address_load_n, burst_advance_n, global_write_n, byte_write_enable_n} = 4'hf;
    {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h2;
    byte_lane_write_n = 4'hf;
    {sleep_request, burst_order_select_n, output_enable_n} = 3'h2;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // every address, load, advance, write and data pin is driven on each call (chip selects are not), so nothing floats between commands
  task automatic drive(input logic ld_n, adv_n, gw_n, bwe_n, input logic [3:0] lanes,
    input logic [sss_pkg::ADDR_W-1:0] a, input logic [sss_pkg::DATA_W-1:0] d);
    @(posedge sys_clk);
    address <= a;
    address_load_n <= ld_n;
    burst_advance_n <= adv_n;
    global_write_n <= gw_n;
    byte_write_enable_n <= bwe_n;
    byte_lane_write_n <= lanes;
    data_in <= d;
  endtask : drive

  task automatic pins(input logic sleep, order_n);
    @(posedge sys_clk);
    sleep_request <= sleep;
    burst_order_select_n <= order_n;
  endtask : pins

  task automatic set_oe(input logic oe_n);
    @(posedge sys_clk);
    output_enable_n <= oe_n;
  endtask : set_oe

  task automatic set_sel(input logic [2:0] cs);
    @(posedge sys_clk);
    {chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
  endtask : set_sel
endmodule : sss_host_model

/* File: tb/sync_sram_snooze_and_burst_ctrl_tb.sv */
// Purpose: self-checking bench for snooze entry and exit and burst address order
// Assumes: read data is seen just after the same edge at which the read command is taken
// Notes: expected words come from an address pattern or the written constants, never from the design
`timescale 1ns/1ps
module sync_sram_snooze_and_burst_ctrl_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [sss_pkg::ADDR_W-1:0] address;
  logic address_load_n, burst_advance_n, chip_select_a_n, chip_select_b, chip_select_c_n;
  logic global_write_n, byte_write_enable_n, sleep_request, burst_order_select_n;
  logic output_enable_n, data_oe_n_q, snooze_q;
  logic [sss_pkg::LANES-1:0] byte_lane_write_n;
  logic [sss_pkg::DATA_W-1:0] data_in, data_out_q;
  int bad_count = 0;
  int checks_done = 0;

  always #4 sys_clk = ~sys_clk;

  sss_host_model host (.sys_clk, .address, .address_load_n, .burst_advance_n,
    .chip_select_a_n, .chip_select_b, .chip_select_c_n, .global_write_n,
    .byte_write_enable_n, .byte_lane_write_n, .data_in, .sleep_request,
    .burst_order_select_n, .output_enable_n);
  sss_ctrl dut (.sys_clk, .rstn, .sleep_request, .burst_order_select_n, .output_enable_n,
    .address, .address_load_n, .burst_advance_n, .chip_select_a_n, .chip_select_b,
    .chip_select_c_n, .global_write_n, .byte_write_enable_n, .byte_lane_write_n, .data_in,
    .data_out_q, .data_oe_n_q, .snooze_q);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [31:0] pat(input logic [18:0] a);
    return 32'h5a5a0000 ^ {13'h0, a};
  endfunction : pat

  task automatic idle(input int n);
    repeat (n) host.drive(1'b1, 1'b1, 1'b1, 1'b1, 4'hf, address, ~data_in);
  endtask : idle

  task automatic rd1(input logic [18:0] a, input logic [31:0] exp);
    host.drive(1'b0, 1'b1, 1'b1, 1'b1, 4'hf, a, ~data_in);
    idle(1);
    #1;
    cmp(data_out_q, exp);
  endtask : rd1

  task automatic reset_case();
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    idle(3);
    #1;
    cmp({data_out_q[29:0], data_oe_n_q, snooze_q}, 32'h2);
  endtask : reset_case

  task automatic fill_case();
    for (int i = 0; i < 4; i++)
      host.drive(1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 19'h104 + 19'(i), pat(19'h104 + 19'(i)));
    idle(1);
  endtask : fill_case

  task automatic lane_case();
    host.drive(1'b0, 1'b1, 1'b1, 1'b0, 4'b1010, 19'h104, 32'hffffffff);
    rd1(19'h104, pat(19'h104) | 32'h00ff00ff);
  endtask : lane_case

  // output enable high keeps the bus released although the read still happens
  task automatic oe_case();
    host.set_oe(1'b1);
    idle(2);
    rd1(19'h200, 32'h11112222);
    cmp(32'(data_oe_n_q), 32'h1);
    host.set_oe(1'b0);
    idle(3);
    #1;
    cmp(32'(data_oe_n_q), 32'h0);
  endtask : oe_case

  // a load with the chip deselected ends the burst and must not write
  task automatic deselect_case();
    host.set_sel(3'h3);
    host.drive(1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 19'h200, 32'h0);
    idle(1);
    #1;
    cmp(32'(data_oe_n_q), 32'h1);
    cmp(data_out_q, 32'h11112222);
    host.set_sel(3'h2);
    rd1(19'h200, 32'h11112222);
  endtask : deselect_case

  // reads four beats from a, checking each word and that the output is driven
  task automatic burst(input logic [18:0] a, input logic xor_mode);
    logic [1:0] lo;
    host.drive(1'b0, 1'b1, 1'b1, 1'b1, 4'hf, a, ~data_in);
    for (int i = 0; i < 4; i++)
    begin
      lo = xor_mode ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
      host.drive(1'b1, i == 3, 1'b1, 1'b1, 4'hf, a, ~data_in);
      #1;
      cmp(data_out_q, pat({a[18:2], lo}));
      cmp(32'(data_oe_n_q), 32'h0);
    end
  endtask : burst

  // two writes follow the sleep rise: the first lands, the second falls in snooze
  task automatic snooze_case();
    host.pins(1'b1, 1'b0);
    host.drive(1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 19'h200, 32'h11112222);
    host.drive(1'b0, 1'b1, 1'b0, 1'b1, 4'hf, 19'h104, 32'h0);
    idle(1);
    #1;
    cmp(32'(snooze_q), 32'h1);
    cmp(32'(data_oe_n_q), 32'h1);
    idle(4);
    host.pins(1'b0, 1'b0);
    idle(3);
    #1;
    cmp(32'(snooze_q), 32'h0);
    rd1(19'h200, 32'h11112222);
    rd1(19'h104, pat(19'h104) | 32'h00ff00ff);
  endtask : snooze_case

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    bad_count++;
    conclude();
  end

  initial
  begin
    reset_case();
    fill_case();
    burst(19'h105, 1'b1);
    host.pins(1'b0, 1'b0);
    idle(3);
    burst(19'h107, 1'b0);
    lane_case();
    snooze_case();
    oe_case();
    deselect_case();
    conclude();
  end
endmodule : sync_sram_snooze_and_burst_ctrl_tb
